// file: hw/isolated_bcd_program_port.v
`timescale 1ns/1ns
`include "isolated_bcd_program_port_defines.vh"

module isolated_bcd_program_port (
    input wire clk_sys,
    input wire reset,
    input wire load_request,
    input wire standby_request,
    input wire current_limit,
    input wire [31:0] program_data,
    output reg ready_q,
    output reg overload_q,
    output wire hold,
    output wire standby_cmd,
    output wire polarity_negative,
    output reg external_reference_select_connect_q,
    output wire [23:0] ladder_switch,
    output wire [31:0] command_bits
);

localparam ST_IDLE = 2'b00;
localparam ST_DELAY = 2'b01;
localparam ST_TAIL = 2'b10;

// Counts kept at full width, then cut to their counters on purpose
localparam [31:0] DELAY_FULL = `DELAY_CYC - 1;
localparam [31:0] WINDOW_FULL = `WINDOW_CYC - 1;
localparam [31:0] READY_FULL = `READY_CYC;
localparam [31:0] CONV_FULL = `CONV_CYC - 1;
localparam [31:0] PULSE_FULL = `CONV_PULSES;
localparam [5:0] DELAY_LOAD = DELAY_FULL[5:0];
localparam [5:0] WINDOW_LOAD = WINDOW_FULL[5:0];
localparam [9:0] READY_LOAD = READY_FULL[9:0];
localparam [1:0] CONV_LAST = CONV_FULL[1:0];
localparam [4:0] PULSE_LIMIT = PULSE_FULL[4:0];

////////////////////////////////////////////////////////////////////////////
// Pin synchronisers
reg load_s1_q;
reg load_s2_q;
reg load_s3_q;
reg stby_s1_q;
reg stby_s2_q;
reg ilim_s1_q;
reg ilim_s2_q;
reg [31:0] data_s1_q;
reg [31:0] data_s2_q;

always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
        load_s1_q <= 1'b0;
        load_s2_q <= 1'b0;
        load_s3_q <= 1'b0;
        stby_s1_q <= 1'b0;
        stby_s2_q <= 1'b0;
        ilim_s1_q <= 1'b0;
        ilim_s2_q <= 1'b0;
        data_s1_q <= 32'h00000000;
        data_s2_q <= 32'h00000000;
    end else begin
        load_s1_q <= load_request;
        load_s2_q <= load_s1_q;
        load_s3_q <= load_s2_q;
        stby_s1_q <= standby_request;
        stby_s2_q <= stby_s1_q;
        ilim_s1_q <= current_limit;
        ilim_s2_q <= ilim_s1_q;
        data_s1_q <= program_data;
        data_s2_q <= data_s1_q;
    end
end

// Trailing edge only; the leading edge does nothing
wire load_trail = load_s3_q & ~load_s2_q;

////////////////////////////////////////////////////////////////////////////
// Transfer sequencer
reg [1:0] state_q;
reg [5:0] gate_cnt_q;
reg [5:0] win_cnt_q;
reg window_q;
reg window_n_q;
reg freeze_start_q;
reg gate_end_q;
reg [1:0] state_d;
reg [5:0] gate_cnt_d;
reg accept;

always @* begin
    state_d = state_q;
    gate_cnt_d = gate_cnt_q;
    accept = 1'b0;
    case (state_q)
        ST_IDLE: begin
            // Requests inside a running window never reach here
            if (load_trail) begin
                accept = 1'b1;
                state_d = ST_DELAY;
                gate_cnt_d = DELAY_LOAD;
            end
        end
        ST_DELAY: begin
            if (gate_cnt_q == 6'h00) begin
                state_d = ST_TAIL;
            end else begin
                gate_cnt_d = gate_cnt_q - 6'h01;
            end
        end
        ST_TAIL: begin
            if (!window_q) begin
                state_d = ST_IDLE;
            end
        end
        default: begin
            state_d = ST_IDLE;
        end
    endcase
end

always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
        state_q <= ST_IDLE;
        gate_cnt_q <= 6'h00;
        freeze_start_q <= 1'b0;
        gate_end_q <= 1'b0;
    end else begin
        state_q <= state_d;
        gate_cnt_q <= gate_cnt_d;
        freeze_start_q <= accept;
        gate_end_q <= (state_q == ST_DELAY) && (gate_cnt_q == 6'h00);
    end
end

////////////////////////////////////////////////////////////////////////////
// Start/stop window with complementary enables
// Closes on its own count; a new request cannot restart it
always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
        win_cnt_q <= 6'h00;
        window_q <= 1'b0;
        window_n_q <= 1'b1;
    end else begin
        if (accept) begin
            window_q <= 1'b1;
            window_n_q <= 1'b0;
            win_cnt_q <= WINDOW_LOAD;
        end else if (window_q) begin
            if (win_cnt_q == 6'h00) begin
                window_q <= 1'b0;
                window_n_q <= 1'b1;
            end else begin
                win_cnt_q <= win_cnt_q - 6'h01;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// Gated oscillator and serialiser
reg [1:0] phase_q;
reg [4:0] pulse_cnt_q;
reg [3:0] addr_q;
reg ser_clk_q;
reg ser_a_q;
reg ser_b_q;
reg standby_pulse_q;

// Standby keeps the oscillator alive outside the window
wire osc_run = window_q | stby_s2_q;
wire osc_tick = osc_run && (phase_q == CONV_LAST);
wire conv_tick = osc_tick && window_q && (pulse_cnt_q != PULSE_LIMIT);

// Input multiplexer: address k picks bit k and bit 16+k
// Stream B carries the upper half with polarity and reference select
wire [15:0] stream_a;
wire [15:0] stream_b;

genvar k;
generate
    for (k = 0; k < `STREAM_W; k = k + 1) begin : g_mux
        assign stream_a[k] = data_s2_q[k];
        assign stream_b[k] = data_s2_q[`STREAM_W + k];
    end
endgenerate

// Phase counter divides the system clock down to the conversion rate
always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
        phase_q <= 2'b00;
        pulse_cnt_q <= 5'h00;
        addr_q <= 4'h0;
    end else begin
        if (accept) begin
            phase_q <= 2'b00;
            pulse_cnt_q <= 5'h00;
            addr_q <= 4'h0;
        end else if (osc_run) begin
            phase_q <= osc_tick ? 2'b00 : phase_q + 2'b01;
        end else begin
            phase_q <= 2'b00;
        end
        if (conv_tick) begin
            pulse_cnt_q <= pulse_cnt_q + 5'h01;
            addr_q <= addr_q + 4'h1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// Barrier drivers: clock, two bit streams and standby pulses
always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
        ser_clk_q <= 1'b0;
        ser_a_q <= 1'b0;
        ser_b_q <= 1'b0;
        standby_pulse_q <= 1'b0;
    end else begin
        ser_clk_q <= conv_tick;
        if (conv_tick) begin
            ser_a_q <= stream_a[addr_q];
            ser_b_q <= stream_b[addr_q];
        end
        // Complementary enable steers ticks to the standby path
        standby_pulse_q <= osc_tick & stby_s2_q & window_n_q;
    end
end

////////////////////////////////////////////////////////////////////////////
// Overload and ready flag
// One counter serves both the gate tail and the overload tail
reg [9:0] ready_cnt_q;

// Set and cleared by the edges of the synchronised limit level
wire ilim_start = ilim_s2_q & ~overload_q;
wire ilim_end = ~ilim_s2_q & overload_q;
// Not ready through the gate, the one-shot and any overload
wire gate_busy = accept | (state_q == ST_DELAY) | gate_end_q;
wire ovl_busy = ilim_s2_q | overload_q;
wire tail_busy = (ready_cnt_q > 10'h001);

always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
        overload_q <= 1'b0;
        ready_cnt_q <= 10'h000;
        ready_q <= 1'b1;
    end else begin
        if (ilim_start) begin
            overload_q <= 1'b1;
        end else if (ilim_end) begin
            overload_q <= 1'b0;
        end
        if (gate_end_q) begin
            ready_cnt_q <= READY_LOAD;
        end else if (ilim_end) begin
            ready_cnt_q <= READY_LOAD;
        end else if (ready_cnt_q != 10'h000) begin
            ready_cnt_q <= ready_cnt_q - 10'h001;
        end
        ready_q <= !(gate_busy | ovl_busy | tail_busy);
    end
end

////////////////////////////////////////////////////////////////////////////
// Isolated side
wire [31:0] cmd;
wire stby_cmd;

isolated_command_register u_iso (
    .clk_sys(clk_sys),
    .reset(reset),
    .freeze_start(freeze_start_q),
    .ser_clk(ser_clk_q),
    .ser_a(ser_a_q),
    .ser_b(ser_b_q),
    .standby_pulse(standby_pulse_q),
    .hold_q(hold),
    .cmd_q(cmd),
    .standby_cmd_q(stby_cmd)
);

assign command_bits = cmd;
assign standby_cmd = stby_cmd;
assign polarity_negative = cmd[`CMD_POLARITY_BIT];

////////////////////////////////////////////////////////////////////////////
// Ladder drives: one nibble per decade, weights 8-4-2-1, lowest first
genvar d;
generate
    for (d = 0; d < `DECADES; d = d + 1) begin : g_decade
        assign ladder_switch[4*d+3:4*d] = cmd[4*d+3:4*d];
    end
endgenerate

////////////////////////////////////////////////////////////////////////////
// External reference: its own select or a standby command connects it
// Registered so the pin comes straight from a flip-flop
always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
        external_reference_select_connect_q <= 1'b0;
    end else begin
        external_reference_select_connect_q <= cmd[`CMD_EXTREF_BIT] | stby_cmd;
    end
end

endmodule // isolated_bcd_program_port

// file: hw/isolated_bcd_program_port_defines.vh
// Operation
// - Power-up reset presets every counter, flip-flop and register on both sides.
// - Only a load request changes the programmed output after presetting.
// - Transfer timing starts on the trailing edge of the load request.
// - Each accepted request opens a fixed 800 ns delay gate.
// - Delay gate end drives the ready flag not-ready for 30 us.
// - Delay gate start sets the window that enables oscillator and clock gate.
// - Delay gate start fires an 8 us output-freeze pulse on the isolated side.
// - Window lasts 1.6 us with complementary enables; clock gated only inside it.
// - Exactly 16 conversion clock pulses at the 10 MHz rate per window; the code spaces them 2 cycles, 80 ns (12.5 MHz).
// - Each conversion pulse steps a 4-bit address over sixteen input positions.
// - Two serial streams travel with the conversion clock into the isolated side.
// - Isolated shift register rebuilds parallel commands, applied when freeze ends.
// - Standby keeps oscillator running; after window its pulses go to standby path.
// - Standby pulses give a standby command lasting until the next load request.
// - Overload flag set at current-limit start and cleared at its end.
// - Ready flag not-ready during overload and 30 us after it clears.
// - Ladder switch takes the reference when its command bit is high.
// - Each decade takes an 8-4-2-1 digit; position sets its significance.
// - External reference connects when its select or the standby command is on.
// - Preset leaves output at minimum with logic ready for input data.
`ifndef ISOLATED_BCD_PROGRAM_PORT_DEFINES_VH
`define ISOLATED_BCD_PROGRAM_PORT_DEFINES_VH

`define CLK_PERIOD_NS 40
`define T_DELAY_NS 800
`define T_READY_NS 30000
`define T_HOLD_NS 8000
`define T_WINDOW_NS 1600
`define T_CONV_PERIOD_NS 100

// Least times round up to whole cycles
`define DELAY_CYC ((`T_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READY_CYC ((`T_READY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_CYC ((`T_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WINDOW_CYC ((`T_WINDOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Pulse period rounds down so all pulses fit inside the window
`define CONV_CYC (`T_CONV_PERIOD_NS / `CLK_PERIOD_NS)

`define CONV_PULSES 16
`define ADDR_W 4
`define STREAM_W 16
`define CMD_W 32
`define CMD_RESET 32'h00000000
`define DECADES 6
`define CMD_POLARITY_BIT 24
`define CMD_EXTREF_BIT 25

`endif

// file: hw/isolated_command_register.v
`timescale 1ns/1ns
`include "isolated_bcd_program_port_defines.vh"

module isolated_command_register (
    input wire clk_sys,
    input wire reset,
    input wire freeze_start,
    input wire ser_clk,
    input wire ser_a,
    input wire ser_b,
    input wire standby_pulse,
    output reg hold_q,
    output reg [31:0] cmd_q,
    output reg standby_cmd_q
);

reg [15:0] shift_a_q;
reg [15:0] shift_b_q;
reg [9:0] hold_cnt_q;

localparam [31:0] HOLD_FULL = `HOLD_CYC;
localparam [9:0] HOLD_LOAD = HOLD_FULL[9:0];

////////////////////////////////////////////////////////////////////////////
always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
        shift_a_q <= 16'h0000;
        shift_b_q <= 16'h0000;
        hold_cnt_q <= 10'h000;
        hold_q <= 1'b0;
        cmd_q <= `CMD_RESET;
        standby_cmd_q <= 1'b0;
    end else begin
        if (ser_clk) begin
            shift_a_q <= {ser_a, shift_a_q[15:1]};
            shift_b_q <= {ser_b, shift_b_q[15:1]};
        end
        if (freeze_start) begin
            hold_cnt_q <= HOLD_LOAD;
            hold_q <= 1'b1;
        end else if (hold_cnt_q != 10'h000) begin
            hold_cnt_q <= hold_cnt_q - 10'h001;
            if (hold_cnt_q == 10'h001) begin
                hold_q <= 1'b0;
                cmd_q <= {shift_b_q, shift_a_q};
            end
        end
        // Set wins so a pulse in the clearing cycle is kept
        if (standby_pulse) begin
            standby_cmd_q <= 1'b1;
        end else if (freeze_start) begin
            standby_cmd_q <= 1'b0;
        end
    end
end

endmodule // isolated_command_register

// file: sim/host_model.sv
`timescale 1ns/1ns
module host_model (
    output reg load_request,
    output reg standby_request,
    output reg current_limit,
    output reg [31:0] program_data,
    input wire clk_sys
);
    initial begin
        load_request = 1'b0;
        standby_request = 1'b0;
        current_limit = 1'b0;
        program_data = 32'h00000000;
    end
    task tick(input integer n);
        begin
            repeat (n) @(posedge clk_sys);
            #1;
        end
    endtask
    // Data kept until next strobe; caller waits for ready
    task load(input [31:0] d);
        begin
            tick(1);
            program_data = d;
            load_request = 1'b1;
            tick(2);
            load_request = 1'b0;
        end
    endtask
    task lines(input s, input c);
        begin
            tick(1);
            standby_request = s;
            current_limit = c;
        end
    endtask
endmodule // host_model

// file: sim/port_chk.sv
`timescale 1ns/1ns
module port_chk (
    input wire clk_sys,
    input wire reset,
    input wire current_limit,
    input wire ready_q,
    input wire overload_q,
    input wire hold,
    input wire polarity_negative,
    input wire [23:0] ladder_switch,
    input wire [31:0] command_bits
);
    // Run lengths of hold high and of ready low
    reg [9:0] hcnt_q;
    reg [9:0] rcnt_q;
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            hcnt_q <= 10'h000;
            rcnt_q <= 10'h000;
        end else begin
            hcnt_q <= hold ? hcnt_q + 10'h001 : 10'h000;
            rcnt_q <= ready_q ? 10'h000 : rcnt_q + 10'h001;
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    hold_width_a: assert property ($fell(hold) |-> hcnt_q == 10'h0C8)
        else $error("hold width wrong");
    hold_busy_a: assert property (hold |-> !ready_q)
        else $error("ready during hold");
    ready_min_a: assert property ($rose(ready_q) |-> rcnt_q >= 10'h2EE)
        else $error("not-ready too short");
    cmd_change_a: assert property ($changed(command_bits) |-> $past(hold, 2))
        else $error("command changed outside hold end");
    ladder_map_a: assert property (ladder_switch == command_bits[23:0]
        && polarity_negative == command_bits[24])
        else $error("ladder mapping wrong");
    ovl_set_a: assert property ($rose(current_limit) |-> ##[1:4] overload_q)
        else $error("overload not set");
    ovl_clr_a: assert property ($fell(current_limit) |-> ##[1:4] !overload_q)
        else $error("overload not cleared");
    ovl_ready_a: assert property (overload_q |=> !ready_q)
        else $error("ready during overload");
endmodule // port_chk

bind isolated_bcd_program_port port_chk chk (.clk_sys(clk_sys),
    .reset(reset), .current_limit(current_limit), .ready_q(ready_q),
    .overload_q(overload_q), .hold(hold),
    .polarity_negative(polarity_negative),
    .ladder_switch(ladder_switch), .command_bits(command_bits));

// file: sim/testbench.sv
`timescale 1ns/1ns
module testbench;
    reg clk_sys = 1'b0;
    reg reset = 1'b1;
    wire load_request, standby_request, current_limit, ready_q, hold;
    wire overload_q, standby_cmd, polarity_negative, external_reference_select_connect_q;
    wire [31:0] program_data;
    wire [31:0] command_bits;
    wire [23:0] ladder_switch;
    integer num_errors = 0;
    integer n_compared = 0;
    integer waited;
    integer holds = 0;
    reg [31:0] prev = 32'h00000000;
    always #20 clk_sys = ~clk_sys;
    always @(posedge hold) holds = holds + 1;
    host_model host (.clk_sys(clk_sys), .load_request(load_request),
        .standby_request(standby_request), .current_limit(current_limit),
        .program_data(program_data));
    isolated_bcd_program_port dut (.clk_sys(clk_sys), .reset(reset),
        .load_request(load_request), .standby_request(standby_request),
        .current_limit(current_limit), .program_data(program_data),
        .ready_q(ready_q), .overload_q(overload_q), .hold(hold),
        .standby_cmd(standby_cmd), .polarity_negative(polarity_negative),
        .external_reference_select_connect_q(external_reference_select_connect_q),
        .ladder_switch(ladder_switch), .command_bits(command_bits));
    ////////////////////////////////////////
    task check(input [63:0] nm, input [31:0] e, input [31:0] g);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                num_errors = num_errors + 1;
                $display("MISMATCH %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    // Bounded wait on hold (s=0) or ready (s=1)
    task wait_on(input s, input v, input integer lim);
        begin
            waited = 0;
            while ((s ? ready_q : hold) !== v && waited < lim) begin
                host.tick(1);
                waited = waited + 1;
            end
            check("wait", 0, waited == lim);
        end
    endtask
    task t_load(input [31:0] d);
        begin
            host.load(d);
            wait_on(0, 1, 100);
            check("rdy", 0, ready_q);
            check("old", prev, command_bits);
            wait_on(0, 0, 300);
            check("hold", 200, waited);
            check("cmd", d, command_bits);
            check("lad", d[23:0], ladder_switch);
            check("pol", d[24], polarity_negative);
            wait_on(1, 1, 900);
            check("ext", d[25], external_reference_select_connect_q);
            prev = d;
        end
    endtask
    task t_ignore;
        integer h0;
        reg [31:0] dv;
        begin
            h0 = holds;
            dv = 32'h00876543;
            host.load(dv);
            host.tick(8);
            host.load(dv);
            wait_on(1, 1, 1200);
            check("holds", h0 + 1, holds);
            check("cmd2", dv, command_bits);
            prev = dv;
        end
    endtask
    task t_ovl;
        reg [1:0] lv;
        begin
            lv = 2'b01;
            host.lines(lv[1], lv[0]);
            host.tick(50);
            check("ovl", 1, overload_q);
            check("rdy", 0, ready_q);
            lv = 2'b00;
            host.lines(lv[1], lv[0]);
            host.tick(8);
            check("ovl0", 0, overload_q);
            wait_on(1, 1, 1000);
            check("tail", 1, waited >= 32'h2E4);
        end
    endtask
    task t_stby;
        reg [1:0] lv;
        begin
            lv = 2'b10;
            host.lines(lv[1], lv[0]);
            host.tick(60);
            check("sby", 1, standby_cmd);
            lv = 2'b00;
            host.lines(lv[1], lv[0]);
            host.tick(20);
            check("sby2", 1, standby_cmd);
            check("extr", 1, external_reference_select_connect_q);
            t_load(32'h00000000);
            check("sby3", 0, standby_cmd);
        end
    endtask
    task tally_and_finish;
        begin
            $display("Errors %0d of %0d compared", num_errors, n_compared);
            if (num_errors == 0 && n_compared > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        check("rdy0", 1, ready_q);
        check("out0", 0, {hold, standby_cmd, overload_q, command_bits});
        #1 reset = 1'b0;
        host.tick(4);
        check("rdy1", 1, ready_q);
        check("cmd1", 0, command_bits);
        t_load(32'h01234567);
        t_load(32'h03999999);
        t_ignore;
        t_ovl;
        t_stby;
        tally_and_finish;
    end
    // Whole run needs about 160 us
    initial begin
        #1000000;
        num_errors = num_errors + 1;
        tally_and_finish;
    end
endmodule // testbench
